// ==== verilog/adcs_pkg.sv ====
/*
  constants for the conversion sequencer: register offsets, field positions,
  reset values and converter clock timing.
  assumes an 8-bit register port and a 125 MHz system clock.
*/
package adcs_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_A    = 8'h00;
  localparam logic [7:0] OFS_CONTROL_B    = 8'h01;
  localparam logic [7:0] OFS_INPUT_SELECT = 8'h02;
  localparam logic [7:0] OFS_RESULT_LOW   = 8'h03;
  localparam logic [7:0] OFS_RESULT_HIGH  = 8'h04;
  localparam logic [7:0] OFS_POWER        = 8'h05;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CA_ENABLE   = 7;
  localparam int CA_START    = 6;
  localparam int CA_AUTO     = 5;
  localparam int CA_FLAG     = 4;
  localparam int CA_IRQ_EN   = 3;
  localparam int PS_MSB      = 2;
  localparam int TS_MSB      = 2;
  localparam int IS_REF_MSB  = 7;
  localparam int IS_REF_LSB  = 6;
  localparam int IS_LEFT     = 5;
  localparam int IS_CH_MSB   = 3;
  localparam int PW_REDUCE   = 0;
  localparam int RES_BITS    = 10;
  localparam int LOW_BITS    = 8;
  // ----------------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [2:0] TS_FREE_RUN = 3'h0;
  localparam logic [6:0] PRESC_FULL  = 7'h7f;
  localparam logic [2:0] PRESC_TOP   = 3'h7;
  // ----------------------------------------------------------------------
  // converter clock timing, counted in whole and half converter clock cycles
  // ----------------------------------------------------------------------
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES  = 25;
  localparam int AUTO_HALVES   = 27;  // 13.5 cycles
  localparam int SH_NORMAL_HALVES = 3;  // 1.5 cycles
  localparam int SH_FIRST_HALVES  = 27; // 13.5 cycles
  localparam int SH_AUTO_HALVES   = 4;  // 2 cycles
  localparam int TRIG_SYNC_CYCLES = 3;
  localparam logic [5:0] LEN_NORMAL = 6'(NORMAL_CYCLES * 2);
  localparam logic [5:0] LEN_FIRST  = 6'(FIRST_CYCLES * 2);
  localparam logic [5:0] LEN_AUTO   = 6'(AUTO_HALVES);
  localparam logic [5:0] SH_NORMAL  = 6'(SH_NORMAL_HALVES);
  localparam logic [5:0] SH_FIRST   = 6'(SH_FIRST_HALVES);
  localparam logic [5:0] SH_AUTO    = 6'(SH_AUTO_HALVES);
  localparam logic [5:0] LAST_CYCLE = 6'h02;

  typedef enum logic [1:0] {ADCS_IDLE, ADCS_ARMED, ADCS_CONV} adcs_state_t;
endpackage

// ==== verilog/adcs_sequencer.sv ====
/*
  digital control of a 10-bit successive approximation converter: start
  control, prescaled converter clock, conversion timing, result alignment
  and the low/high result read lock.
  assumes the analog array returns its result on sar_result_in by the end
  of each conversion and that all inputs are synchronous to ref_clk_in.
*/
// The register addresses and the address-and-strobe port were chosen for this implementation.
// Overview of operation
// - 10-bit result, right aligned by default, left aligned when bit set.
// - channel and reference selections only take effect while enabled.
// - low read locks both result registers until high read; lost results.
// - done flag still set when the result was discarded.
// - start bit begins conversion, stays one, hardware clears at completion.
// - channel change mid-conversion applies after current conversion.
// - auto trigger rising edge resets prescaler and starts conversion.
// - trigger level at completion or edges during conversion are ignored.
// - flags set regardless of enables; software clears trigger flag.
// - done flag as trigger source restarts at every completion.
// - software start works with auto trigger; start reads one when busy.
// - prescaler runs while enabled, held in reset while disabled.
// - software start begins at next rising converter clock edge.
// - normal conversion 13 converter cycles, first one 25.
// - sample and hold at 1.5 cycles, 13.5 for the first conversion.
// - completion writes result, sets flag, clears start in single mode.
// - auto conversion samples after two cycles, lasts 13.5 cycles.
// - free running restarts immediately, start bit stays high.
// - power reduction bit makes the converter inoperative.
// - selection buffer tracks until start, freezes, resumes last cycle.
`timescale 1ns/1ps
module adcs_sequencer
(
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         reset_in,
  // register port
  input  wire logic [7:0]   addr_in,
  input  wire logic [7:0]   wdata_in,
  input  wire logic         wr_in,
  input  wire logic         rd_in,
  output logic      [7:0]   rdata_out,
  // events and analog side
  input  wire logic [7:0]   trigger_in,
  input  wire logic [9:0]   sar_result_in,
  output logic              converter_clk_out,
  output logic              sample_hold_out,
  output logic              analog_enable_out,
  output logic      [3:0]   channel_out,
  output logic      [1:0]   reference_out,
  output logic              done_irq_out
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  adcs_pkg::adcs_state_t state_r, state_nxt;
  logic [7:0] ctrl_a_r, ctrl_a_nxt;
  logic [2:0] ctrl_b_r, ctrl_b_nxt;
  logic [7:0] insel_r, insel_nxt;
  logic       power_r, power_nxt;
  logic [9:0] result_r, result_nxt;
  logic       lock_r, lock_nxt;
  logic       first_r, first_nxt;
  logic [6:0] presc_r, presc_nxt;
  logic [5:0] hc_r, hc_nxt;
  logic [5:0] len_r, len_nxt;
  logic [5:0] sh_r, sh_nxt;
  logic [2:0] trig_d_r, trig_d_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       cclk_r, cclk_nxt;
  logic       sample_r, sample_nxt;
  logic       aen_r, aen_nxt;
  logic [3:0] ch_r, ch_nxt;
  logic [1:0] ref_r, ref_nxt;
  logic       irq_r, irq_nxt;

  logic       en_eff, auto_on, free_run, rise, fall, half, done_p, trig_edge;
  logic [2:0] k;
  logic [6:0] mask;
  logic [7:0] res_low, res_high;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_nxt  = state_r;
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    insel_nxt  = insel_r;
    power_nxt  = power_r;
    result_nxt = result_r;
    lock_nxt   = lock_r;
    first_nxt  = first_r;
    hc_nxt     = hc_r;
    len_nxt    = len_r;
    sh_nxt     = sh_r;
    ch_nxt     = ch_r;
    ref_nxt    = ref_r;
    rdata_nxt  = 8'h00;
    sample_nxt = 1'b0;
    en_eff   = ctrl_a_r[adcs_pkg::CA_ENABLE] & ~power_r;
    auto_on  = ctrl_a_r[adcs_pkg::CA_AUTO];
    free_run = auto_on && (ctrl_b_r == adcs_pkg::TS_FREE_RUN);
    k    = (ctrl_a_r[adcs_pkg::PS_MSB:0] == 3'h0) ? 3'h1
         : ctrl_a_r[adcs_pkg::PS_MSB:0];
    mask = adcs_pkg::PRESC_FULL >> (adcs_pkg::PRESC_TOP - k);
    rise = en_eff && ((presc_r & mask) == mask);
    fall = en_eff && ((presc_r & mask) == (mask >> 1));
    half = rise | fall;
    // prescaler held in reset while disabled
    presc_nxt = en_eff ? presc_r + 7'h01 : 7'h00;
    cclk_nxt  = !en_eff ? 1'b0 : rise ? 1'b1 : fall ? 1'b0 : cclk_r;
    // edge detect of trigger after sync delay
    trig_d_nxt = {trig_d_r[1:0], trigger_in[ctrl_b_r]};
    trig_edge  = trig_d_r[1] & ~trig_d_r[2];
    done_p     = (state_r == adcs_pkg::ADCS_CONV) && half
              && (hc_r == len_r - 6'h01);
    if (insel_r[adcs_pkg::IS_LEFT])
    begin
      res_high = result_r[9:2];
      res_low  = {result_r[1:0], 6'h00};
    end
    else
    begin
      res_high = {6'h00, result_r[9:8]};
      res_low  = result_r[7:0];
    end

    // register reads
    if (rd_in)
    begin
      unique case (addr_in)
        adcs_pkg::OFS_CONTROL_A:    rdata_nxt = ctrl_a_r;
        adcs_pkg::OFS_CONTROL_B:    rdata_nxt = {5'h00, ctrl_b_r};
        adcs_pkg::OFS_INPUT_SELECT: rdata_nxt = insel_r;
        adcs_pkg::OFS_RESULT_LOW:   rdata_nxt = res_low;
        adcs_pkg::OFS_RESULT_HIGH:  rdata_nxt = res_high;
        adcs_pkg::OFS_POWER:        rdata_nxt = {7'h00, power_r};
        default:                    rdata_nxt = 8'h00;
      endcase
      // low read locks, high read releases
      if (addr_in == adcs_pkg::OFS_RESULT_LOW)
        lock_nxt = 1'b1;
      else if (addr_in == adcs_pkg::OFS_RESULT_HIGH)
        lock_nxt = 1'b0;
    end

    // register writes
    if (wr_in)
    begin
      unique case (addr_in)
        adcs_pkg::OFS_CONTROL_A:
        begin
          ctrl_a_nxt[adcs_pkg::CA_ENABLE] = wdata_in[adcs_pkg::CA_ENABLE];
          ctrl_a_nxt[adcs_pkg::CA_AUTO]   = wdata_in[adcs_pkg::CA_AUTO];
          ctrl_a_nxt[adcs_pkg::CA_IRQ_EN] = wdata_in[adcs_pkg::CA_IRQ_EN];
          ctrl_a_nxt[adcs_pkg::PS_MSB:0]  = wdata_in[adcs_pkg::PS_MSB:0];
          if (wdata_in[adcs_pkg::CA_FLAG])
            ctrl_a_nxt[adcs_pkg::CA_FLAG] = 1'b0;
          // software start sets the start bit
          // software start also works with auto trigger on
          if (wdata_in[adcs_pkg::CA_START] && en_eff
              && state_r == adcs_pkg::ADCS_IDLE)
          begin
            ctrl_a_nxt[adcs_pkg::CA_START] = 1'b1;
            state_nxt = adcs_pkg::ADCS_ARMED;
          end
        end
        adcs_pkg::OFS_CONTROL_B:
          ctrl_b_nxt = wdata_in[adcs_pkg::TS_MSB:0];
        adcs_pkg::OFS_INPUT_SELECT:
          insel_nxt = {wdata_in[7:5], 1'b0, wdata_in[3:0]};
        adcs_pkg::OFS_POWER:
          power_nxt = wdata_in[adcs_pkg::PW_REDUCE];
        default:
        begin
        end
      endcase
    end

    // auto trigger edge starts at once and resets the prescaler
    if (auto_on && !free_run && en_eff && trig_edge
        && state_r == adcs_pkg::ADCS_IDLE)
    begin
      presc_nxt = 7'h00;
      cclk_nxt  = 1'b1;
      state_nxt = adcs_pkg::ADCS_CONV;
      ctrl_a_nxt[adcs_pkg::CA_START] = 1'b1;
      hc_nxt    = 6'h00;
      first_nxt = 1'b0;
      len_nxt = first_r ? adcs_pkg::LEN_FIRST : adcs_pkg::LEN_AUTO;
      sh_nxt  = first_r ? adcs_pkg::SH_FIRST : adcs_pkg::SH_AUTO;
    end

    unique case (state_r)
      adcs_pkg::ADCS_IDLE:
      begin
      end
      adcs_pkg::ADCS_ARMED:
        // begin on the next rising converter clock edge
        if (rise)
        begin
          state_nxt = adcs_pkg::ADCS_CONV;
          hc_nxt    = 6'h00;
          first_nxt = 1'b0;
          len_nxt = first_r ? adcs_pkg::LEN_FIRST : adcs_pkg::LEN_NORMAL;
          sh_nxt  = first_r ? adcs_pkg::SH_FIRST : adcs_pkg::SH_NORMAL;
        end
      adcs_pkg::ADCS_CONV:
        if (half)
        begin
          hc_nxt = hc_r + 6'h01;
          if (hc_r == sh_r)
            sample_nxt = 1'b1;
          if (done_p)
          begin
            hc_nxt = 6'h00;
            if (!lock_r)
              result_nxt = sar_result_in;
            // flag set even if result lost
            ctrl_a_nxt[adcs_pkg::CA_FLAG] = 1'b1;
            // done flag source restarts regardless of the flag
            if (free_run)
            begin
              // start stays high while free running
              len_nxt = adcs_pkg::LEN_NORMAL;
              sh_nxt  = adcs_pkg::SH_NORMAL;
            end
            else
            begin
              // single mode clears start with the flag
              ctrl_a_nxt[adcs_pkg::CA_START] = 1'b0;
              state_nxt = adcs_pkg::ADCS_IDLE;
            end
          end
        end
    endcase

    // selection buffer tracks except while converting
    // new channel taken only in the final cycle
    if (en_eff && (state_r != adcs_pkg::ADCS_CONV
        || hc_r + adcs_pkg::LAST_CYCLE >= len_r))
    begin
      ch_nxt  = insel_r[adcs_pkg::IS_CH_MSB:0];
      ref_nxt = insel_r[adcs_pkg::IS_REF_MSB:adcs_pkg::IS_REF_LSB];
    end

    // disabling aborts any conversion and rearms the long first one
    if (!en_eff)
    begin
      state_nxt = adcs_pkg::ADCS_IDLE;
      ctrl_a_nxt[adcs_pkg::CA_START] = 1'b0;
      first_nxt = 1'b1;
      hc_nxt    = 6'h00;
    end
    aen_nxt = en_eff;
    // flag set regardless of its enable; enable only gates output
    irq_nxt = ctrl_a_nxt[adcs_pkg::CA_FLAG] & ctrl_a_r[adcs_pkg::CA_IRQ_EN];
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      // all controls cleared, disabled and idle
      state_r  <= adcs_pkg::ADCS_IDLE;
      ctrl_a_r <= adcs_pkg::CTRL_RESET;
      ctrl_b_r <= 3'h0;
      insel_r  <= adcs_pkg::CTRL_RESET;
      power_r  <= 1'b0;
      result_r <= 10'h000;
      lock_r   <= 1'b0;
      first_r  <= 1'b1;
      presc_r  <= 7'h00;
      hc_r     <= 6'h00;
      len_r    <= adcs_pkg::LEN_NORMAL;
      sh_r     <= adcs_pkg::SH_NORMAL;
      trig_d_r <= 3'h0;
      rdata_r  <= 8'h00;
      cclk_r   <= 1'b0;
      sample_r <= 1'b0;
      aen_r    <= 1'b0;
      ch_r     <= 4'h0;
      ref_r    <= 2'h0;
      irq_r    <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      insel_r  <= insel_nxt;
      power_r  <= power_nxt;
      result_r <= result_nxt;
      lock_r   <= lock_nxt;
      first_r  <= first_nxt;
      presc_r  <= presc_nxt;
      hc_r     <= hc_nxt;
      len_r    <= len_nxt;
      sh_r     <= sh_nxt;
      trig_d_r <= trig_d_nxt;
      rdata_r  <= rdata_nxt;
      cclk_r   <= cclk_nxt;
      sample_r <= sample_nxt;
      aen_r    <= aen_nxt;
      ch_r     <= ch_nxt;
      ref_r    <= ref_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign rdata_out         = rdata_r;
  assign converter_clk_out = cclk_r;
  assign sample_hold_out   = sample_r;
  assign analog_enable_out = aen_r;
  assign channel_out       = ch_r;
  assign reference_out     = ref_r;
  assign done_irq_out      = irq_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_busy_reads_start: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    state_r == adcs_pkg::ADCS_CONV |-> ctrl_a_r[adcs_pkg::CA_START])
    else $error("start bit low during conversion");

  a_lock_holds_result: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    lock_r && done_p |=> $stable(result_r))
    else $error("result updated while locked");

  a_flag_on_done: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    done_p |=> ctrl_a_r[adcs_pkg::CA_FLAG])
    else $error("done flag not set at completion");

  a_presc_held: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    !en_eff |=> presc_r == 7'h00 && !cclk_r)
    else $error("prescaler runs while disabled");

  a_single_clears: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    done_p && !free_run |=> !ctrl_a_r[adcs_pkg::CA_START]
      && state_r == adcs_pkg::ADCS_IDLE)
    else $error("start not cleared at single completion");

  a_free_restart: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    done_p && free_run && en_eff |=> state_r == adcs_pkg::ADCS_CONV
      && ctrl_a_r[adcs_pkg::CA_START] && hc_r == 6'h00)
    else $error("free running did not restart");

  a_sel_frozen: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    state_r == adcs_pkg::ADCS_CONV && hc_r + adcs_pkg::LAST_CYCLE < len_r
      |=> $stable(ch_r) && $stable(ref_r))
    else $error("selection changed mid conversion");

  a_sample_pulse: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    state_r == adcs_pkg::ADCS_CONV && half && hc_r == sh_r
      |=> sample_r ##1 !sample_r)
    else $error("sample pulse missing");

  a_armed_on_rise: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    state_r == adcs_pkg::ADCS_ARMED && !rise && en_eff
      |=> state_r == adcs_pkg::ADCS_ARMED)
    else $error("conversion began off a rising edge");

endmodule // adcs_sequencer

// ==== sim/adcs_cpu_model.sv ====
/*
  processor core model: drives the register port of the sequencer.
  assumes a rising-edge system clock and the one-cycle read latency.
*/
`timescale 1ns/1ps
module adcs_cpu_model
(
  // clock
  input  wire logic       ref_clk_in,
  // register port
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in
);
  initial
  begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // ----------------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------------
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge ref_clk_in);
    wr_out    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge ref_clk_in);
    rd_out   <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule // adcs_cpu_model

// ==== sim/tb_top.sv ====
/*
  self-checking bench for the conversion sequencer.
  assumes the cpu model for register access; the bench drives events
  and the analog result.
*/
`timescale 1ns/1ps
module tb_top;
  logic       ref_clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] trigger_in = 8'h00;
  logic [9:0] sar_result_in = 10'h000;
  logic       converter_clk_out;
  logic       sample_hold_out;
  logic [3:0] channel_out;
  logic [1:0] reference_out;
  logic       analog_enable_out;
  logic       done_irq_out;
  int         errors = 0;
  int         total_checks = 0;
  int         n;
  int         sh;
  logic       seen;

  always #4 ref_clk_in = ~ref_clk_in;

  adcs_cpu_model cpu
  (
    .ref_clk_in (ref_clk_in),
    .addr_out   (addr),
    .wdata_out  (wdata),
    .wr_out     (wr),
    .rd_out     (rd),
    .rdata_in   (rdata)
  );

  adcs_sequencer uut
  (
    .ref_clk_in        (ref_clk_in),
    .reset_in          (reset_in),
    .addr_in           (addr),
    .wdata_in          (wdata),
    .wr_in             (wr),
    .rd_in             (rd),
    .rdata_out         (rdata),
    .trigger_in        (trigger_in),
    .sar_result_in     (sar_result_in),
    .converter_clk_out (converter_clk_out),
    .sample_hold_out   (sample_hold_out),
    .analog_enable_out (analog_enable_out),
    .channel_out       (channel_out),
    .reference_out     (reference_out),
    .done_irq_out      (done_irq_out)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.read_reg(a, d);
    check(d, e);
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    check(8'(v >= lo && v <= hi), 8'h01);
  endtask

  // any high level of the converter clock over eight cycles
  task automatic watch_clk(output logic s);
    s = 1'b0;
    repeat (8)
    begin
      @(posedge ref_clk_in);
      #1;
      s = s | converter_clk_out;
    end
  endtask

  // cycles until the done level rises, with sample pulses seen meanwhile
  task automatic wait_done(output int cyc, output int pulses);
    cyc = 0;
    pulses = 0;
    do
    begin
      @(posedge ref_clk_in);
      #1;
      cyc++;
      if (sample_hold_out === 1'b1)
        pulses++;
    end
    while (done_irq_out !== 1'b1 && cyc < 400);
  endtask

  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rd_chk(adcs_pkg::OFS_CONTROL_A, 8'h00);
    rd_chk(8'h07, 8'h00);
    cpu.write_reg(adcs_pkg::OFS_INPUT_SELECT, 8'h05);
    watch_clk(seen);
    check({7'h00, seen}, 8'h00);
    check({4'h0, channel_out}, 8'h00);
    cpu.write_reg(adcs_pkg::OFS_POWER, 8'h01);
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hc8);
    rd_chk(adcs_pkg::OFS_CONTROL_A, 8'h88);
    check({7'h00, analog_enable_out}, 8'h00);
    // power reduction lifted before starting
    cpu.write_reg(adcs_pkg::OFS_POWER, 8'h00);
    watch_clk(seen);
    check({7'h00, seen}, 8'h01);
    check({7'h00, analog_enable_out}, 8'h01);
    @(posedge ref_clk_in);
    sar_result_in <= 10'h2a5;
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hc8);
    wait_done(n, sh);
    rng(n, 50, 60);
    check(8'(sh), 8'h01);
    check({4'h0, channel_out}, 8'h05);
    rd_chk(adcs_pkg::OFS_CONTROL_A, 8'h98);
    rd_chk(adcs_pkg::OFS_RESULT_LOW, 8'ha5);
    rd_chk(adcs_pkg::OFS_RESULT_HIGH, 8'h02);
    // low read locks, next result is lost
    rd_chk(adcs_pkg::OFS_RESULT_LOW, 8'ha5);
    @(posedge ref_clk_in);
    sar_result_in <= 10'h155;
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hd8);
    wait_done(n, sh);
    rng(n, 26, 34);
    rd_chk(adcs_pkg::OFS_RESULT_HIGH, 8'h02);
    rd_chk(adcs_pkg::OFS_CONTROL_A, 8'h98);
    cpu.write_reg(adcs_pkg::OFS_INPUT_SELECT, 8'h65);
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hd8);
    // channel changed once the conversion has begun
    cpu.write_reg(adcs_pkg::OFS_INPUT_SELECT, 8'h63);
    repeat (4) @(posedge ref_clk_in);
    #1;
    check({4'h0, channel_out}, 8'h05);
    wait_done(n, sh);
    check({4'h0, channel_out}, 8'h03);
    check({6'h00, reference_out}, 8'h01);
    rd_chk(adcs_pkg::OFS_RESULT_LOW, 8'h40);
    rd_chk(adcs_pkg::OFS_RESULT_HIGH, 8'h55);
    // divide by four doubles the conversion
    // fast converter clock: reduced resolution is accepted here
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hda);
    rd_chk(adcs_pkg::OFS_CONTROL_A, 8'hca);
    wait_done(n, sh);
    rng(n, 48, 64);
    cpu.write_reg(adcs_pkg::OFS_CONTROL_B, 8'h01);
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hb8);
    @(posedge ref_clk_in);
    trigger_in <= 8'h02;
    wait_done(n, sh);
    rng(n, 27, 36);
    // flag cleared by software, trigger level left high
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hb8);
    repeat (80) @(posedge ref_clk_in);
    #1;
    check({7'h00, done_irq_out}, 8'h00);
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hf8);
    wait_done(n, sh);
    rng(n, 26, 34);
    @(posedge ref_clk_in);
    trigger_in <= 8'h00;
    cpu.write_reg(adcs_pkg::OFS_CONTROL_B, 8'h00);
    // first free-running conversion started by software
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'hf8);
    wait_done(n, sh);
    rd_chk(adcs_pkg::OFS_CONTROL_A, 8'hf8);
    repeat (40) @(posedge ref_clk_in);
    rd_chk(adcs_pkg::OFS_CONTROL_A, 8'hf8);
    cpu.write_reg(adcs_pkg::OFS_CONTROL_A, 8'h10);
    rd_chk(adcs_pkg::OFS_CONTROL_A, 8'h00);
    watch_clk(seen);
    check({7'h00, seen}, 8'h00);
    check({7'h00, analog_enable_out}, 8'h00);
    print_verdict();
  end
endmodule // tb_top
